// *** rtl/gate_ctrl_pkg.sv ***
// constants shared by the inverter gate command controller
// assumes a 40 MHz controller clock and an open-drain enable/fault line with pull-up
package gate_ctrl_pkg;
  localparam int    CLK_MHZ        = 40;
  localparam int    CLK_PERIOD_NS  = 25;
  localparam int    DEAD_TIME_NS   = 1000;
  localparam int    DEAD_CYC       = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int    MIN_PULSE_NS   = 1000;
  localparam int    MIN_PULSE_CYC  = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int    NUM_PHASES     = 3;
  localparam int    CNT_W          = 16;
  localparam logic [1:0] CMD_OFF   = 2'h0;
  localparam logic [1:0] CMD_HIGH  = 2'h1;
  localparam logic [1:0] CMD_LOW   = 2'h2;
endpackage : gate_ctrl_pkg

// *** rtl/gate_ctrl_top.sv ***
// controller side of a three-phase inverter module: gate commands and enable/fault line handling
// assumes an external pull-up on the enable/fault line; the module pulls it low on its faults
//
// Summary of operation
// - controller inserts dead time between commands
// - six active-high commands, U V W order
// - controller avoids pulses under 1 us, except on-pulses cut short by a fault or run low
// - shared line: active-high enable, open-drain fault
// - controller drives line low upon fault
`timescale 1ns/10ps
module gate_ctrl_top
  import gate_ctrl_pkg::*;
(
  input  wire logic       I_MCLK,                    // 40 MHz clock
  input  wire logic       I_RST,                     // sync reset, high
  input  wire logic [1:0] I_REQ_U,                   // phase U request: 0 off, 1 high, 2 low
  input  wire logic [1:0] I_REQ_V,                   // phase V request
  input  wire logic [1:0] I_REQ_W,                   // phase W request
  input  wire logic       I_RUN,                     // software run enable
  input  wire logic       I_FAULT_CLEAR,             // pulse: leave latched fault state
  input  wire logic       I_ENABLE_FAULT_N_LINE,     // enable/fault line level from pin
  output logic            O_ENABLE_FAULT_N_LINE,     // line output value (always 0)
  output logic            O_ENABLE_FAULT_N_LINE_OE,  // high while pulling the line low
  output logic            O_HIGH_SIDE_CMD_U,         // high-side command U
  output logic            O_HIGH_SIDE_CMD_V,         // high-side command V
  output logic            O_HIGH_SIDE_CMD_W,         // high-side command W
  output logic            O_LOW_SIDE_CMD_U,          // low-side command U
  output logic            O_LOW_SIDE_CMD_V,          // low-side command V
  output logic            O_LOW_SIDE_CMD_W,          // low-side command W
  output logic            O_FAULT_LATCHED            // fault seen and held
);
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       drove_d1;
    logic       drove_d2;
    logic       fault;
    logic [5:0] cmd;
  } top_t;
  top_t cur;
  top_t next_cur;

  logic [1:0] req   [NUM_PHASES];
  logic [1:0] req_q [NUM_PHASES];
  logic [NUM_PHASES-1:0] leg_high;
  logic [NUM_PHASES-1:0] leg_low;
  logic       block;

  assign req[0] = I_REQ_U;
  assign req[1] = I_REQ_V;
  assign req[2] = I_REQ_W;

  // the module drives the line low for control supply undervoltage and overcurrent alike, so any low
  // not caused by us is treated as a module fault
  // our own low needs two synchroniser edges to leave sync2, so it is masked by a copy of the
  // enable delayed alike; without it every release would latch a false fault
  wire line_low_ext = !cur.sync2 && !cur.drove_d2 && !O_ENABLE_FAULT_N_LINE_OE;

  // while disabled the legs are idled so nothing resumes by itself after the module timeout
  assign block = cur.fault || !I_RUN;

  genvar g;
  generate
    for (g = 0; g < NUM_PHASES; g++) begin : g_leg
      assign req_q[g] = req[g];
      phase_leg_ctrl u_leg (
        .i_mclk (I_MCLK),
        .i_rst  (I_RST),
        .i_req  (req_q[g]),
        .i_block(block),
        .o_high (leg_high[g]),
        .o_low  (leg_low[g])
      );

      // checks on the registered pin commands of this phase, after the output stage
      property p_pin_gap_hl;
        @(posedge I_MCLK) disable iff (I_RST) $fell(cur.cmd[g]) |-> !cur.cmd[g+3] [*8];
      endproperty
      a_pin_gap_hl: assert property (p_pin_gap_hl) else $error("low pin on too soon after high");

      property p_pin_gap_lh;
        @(posedge I_MCLK) disable iff (I_RST) $fell(cur.cmd[g+3]) |-> !cur.cmd[g] [*8];
      endproperty
      a_pin_gap_lh: assert property (p_pin_gap_lh) else $error("high pin on too soon after low");

      property p_pin_min_on_hi;
        @(posedge I_MCLK) disable iff (I_RST || block) $rose(cur.cmd[g]) |-> cur.cmd[g] [*8];
      endproperty
      a_pin_min_on_hi: assert property (p_pin_min_on_hi) else $error("high pin pulse too short");

      property p_pin_min_on_lo;
        @(posedge I_MCLK) disable iff (I_RST || block) $rose(cur.cmd[g+3]) |-> cur.cmd[g+3] [*8];
      endproperty
      a_pin_min_on_lo: assert property (p_pin_min_on_lo) else $error("low pin pulse too short");

      property p_pin_min_off_hi;
        @(posedge I_MCLK) disable iff (I_RST) $fell(cur.cmd[g]) |-> !cur.cmd[g] [*8];
      endproperty
      a_pin_min_off_hi: assert property (p_pin_min_off_hi) else $error("high pin off pulse too short");

      property p_pin_min_off_lo;
        @(posedge I_MCLK) disable iff (I_RST) $fell(cur.cmd[g+3]) |-> !cur.cmd[g+3] [*8];
      endproperty
      a_pin_min_off_lo: assert property (p_pin_min_off_lo) else $error("low pin off pulse too short");

      property p_pin_src_hi;
        @(posedge I_MCLK) disable iff (I_RST) $rose(cur.cmd[g]) |-> ($past(req_q[g], 2) == CMD_HIGH);
      endproperty
      a_pin_src_hi: assert property (p_pin_src_hi) else $error("high pin on without request");

      property p_pin_src_lo;
        @(posedge I_MCLK) disable iff (I_RST) $rose(cur.cmd[g+3]) |-> ($past(req_q[g], 2) == CMD_LOW);
      endproperty
      a_pin_src_lo: assert property (p_pin_src_lo) else $error("low pin on without request");
    end
  endgenerate

  always_comb begin
    next_cur       = cur;
    next_cur.sync1 = I_ENABLE_FAULT_N_LINE;
    next_cur.sync2 = cur.sync1;
    next_cur.drove_d1 = O_ENABLE_FAULT_N_LINE_OE;
    next_cur.drove_d2 = cur.drove_d1;
    // a new fault wins over a clear in the same cycle
    if (I_FAULT_CLEAR) begin
      next_cur.fault = 1'b0;
    end
    if (line_low_ext) begin
      next_cur.fault = 1'b1;
    end
    // registered commands; all off while a fault is latched or run is low
    next_cur.cmd = block ? 6'h00 : {leg_low, leg_high};
    if (I_RST) begin
      next_cur.sync1 = 1'b1;
      next_cur.sync2 = 1'b1;
      next_cur.drove_d1 = 1'b1;
      next_cur.drove_d2 = 1'b1;
      next_cur.fault = 1'b0;
      next_cur.cmd   = 6'h00;
    end
  end

  always_ff @(posedge I_MCLK) begin
    cur <= next_cur;
  end

  assign O_ENABLE_FAULT_N_LINE    = 1'b0;
  // hold the line low on fault or when not running, so the module stays disabled
  assign O_ENABLE_FAULT_N_LINE_OE = cur.fault || !I_RUN;
  assign O_HIGH_SIDE_CMD_U        = cur.cmd[0];
  assign O_HIGH_SIDE_CMD_V        = cur.cmd[1];
  assign O_HIGH_SIDE_CMD_W        = cur.cmd[2];
  assign O_LOW_SIDE_CMD_U         = cur.cmd[3];
  assign O_LOW_SIDE_CMD_V         = cur.cmd[4];
  assign O_LOW_SIDE_CMD_W         = cur.cmd[5];
  assign O_FAULT_LATCHED          = cur.fault;

  property p_fault_latch;
    @(posedge I_MCLK) disable iff (I_RST) line_low_ext |=> O_FAULT_LATCHED && O_ENABLE_FAULT_N_LINE_OE;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("external low not latched");

  property p_fault_gates_off;
    @(posedge I_MCLK) disable iff (I_RST) O_FAULT_LATCHED |=> (cur.cmd == 6'h00);
  endproperty
  a_fault_gates_off: assert property (p_fault_gates_off) else $error("gates on during fault");

  property p_hold_until_clear;
    @(posedge I_MCLK) disable iff (I_RST) O_FAULT_LATCHED && !I_FAULT_CLEAR |=> O_FAULT_LATCHED;
  endproperty
  a_hold_until_clear: assert property (p_hold_until_clear) else $error("fault dropped without clear");

  property p_no_cross;
    @(posedge I_MCLK) disable iff (I_RST)
      !(cur.cmd[0] && cur.cmd[3]) && !(cur.cmd[1] && cur.cmd[4]) && !(cur.cmd[2] && cur.cmd[5]);
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("high and low both commanded");

  property p_stop_off;
    @(posedge I_MCLK) disable iff (I_RST) !I_RUN |=> (cur.cmd == 6'h00);
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("gates on while not running");

  property p_oe_follows;
    @(posedge I_MCLK) disable iff (I_RST) O_ENABLE_FAULT_N_LINE_OE |=> (cur.cmd == 6'h00);
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("gates on while line held low");

  property p_release_mask;
    @(posedge I_MCLK) disable iff (I_RST) $fell(O_ENABLE_FAULT_N_LINE_OE) |-> !line_low_ext ##1 !line_low_ext;
  endproperty
  a_release_mask: assert property (p_release_mask) else $error("own release seen as external low");

  property p_no_spurious;
    @(posedge I_MCLK) disable iff (I_RST) !O_FAULT_LATCHED && !line_low_ext |=> !O_FAULT_LATCHED;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("fault set without external low");

  property p_clear_takes;
    @(posedge I_MCLK) disable iff (I_RST) O_FAULT_LATCHED && I_FAULT_CLEAR |=> !O_FAULT_LATCHED;
  endproperty
  a_clear_takes: assert property (p_clear_takes) else $error("clear ignored while latched");

  property p_ext_low_stops;
    @(posedge I_MCLK) disable iff (I_RST) line_low_ext |-> ##2 (cur.cmd == 6'h00);
  endproperty
  a_ext_low_stops: assert property (p_ext_low_stops) else $error("gates on after external low");

  property p_run_release;
    @(posedge I_MCLK) disable iff (I_RST) $rose(I_RUN) && !O_FAULT_LATCHED |=> !O_FAULT_LATCHED ##1 !O_FAULT_LATCHED;
  endproperty
  a_run_release: assert property (p_run_release) else $error("fault latched on own release");
endmodule : gate_ctrl_top

// *** rtl/phase_leg_ctrl.sv ***
// one phase leg: turns a requested state into high/low commands with dead time and min pulse width
// assumes the request is synchronous to i_mclk and i_block is already synchronised
`timescale 1ns/10ps
module phase_leg_ctrl
  import gate_ctrl_pkg::*;
#(
  parameter int DEAD  = DEAD_CYC,
  parameter int MINP  = MIN_PULSE_CYC
) (
  input  wire logic       i_mclk,    // clock
  input  wire logic       i_rst,     // sync reset, high
  input  wire logic [1:0] i_req,     // requested leg state
  input  wire logic       i_block,   // force both commands off
  output logic            o_high,    // high-side command
  output logic            o_low      // low-side command
);
  typedef enum logic [1:0] {S_OFF, S_DEAD, S_HIGH, S_LOW} leg_state_t;
  typedef struct packed {
    leg_state_t       st;
    logic [CNT_W-1:0] cnt;
  } leg_t;
  leg_t cur;
  leg_t next_cur;

  always_comb begin
    next_cur = cur;
    if (cur.cnt != '0) begin
      next_cur.cnt = cur.cnt - 1'b1;
    end
    if (i_block) begin
      next_cur.st  = S_OFF;
      next_cur.cnt = CNT_W'(DEAD);
    end else begin
      unique case (cur.st)
        S_OFF: begin
          // leaving off only after a full dead interval guards against shoot-through
          if (i_req != CMD_OFF && i_req != 2'h3 && cur.cnt == '0) begin
            next_cur.st  = (i_req == CMD_HIGH) ? S_HIGH : S_LOW;
            next_cur.cnt = CNT_W'(MINP);
          end
        end
        S_DEAD: begin
          if (cur.cnt == '0) begin
            next_cur.st = S_OFF;
          end
        end
        S_HIGH, S_LOW: begin
          // on-pulses shorter than the module can reproduce are stretched
          if (cur.cnt == '0 && ((cur.st == S_HIGH && i_req != CMD_HIGH) ||
                                (cur.st == S_LOW && i_req != CMD_LOW))) begin
            next_cur.st  = S_DEAD;
            next_cur.cnt = CNT_W'((DEAD > MINP) ? DEAD : MINP);
          end
        end
      endcase
    end
    if (i_rst) begin
      next_cur.st     = S_OFF;
      next_cur.cnt    = CNT_W'(DEAD);
    end
  end

  always_ff @(posedge i_mclk) begin
    cur <= next_cur;
  end

  assign o_high = (cur.st == S_HIGH);
  assign o_low  = (cur.st == S_LOW);

  property p_no_overlap;
    @(posedge i_mclk) disable iff (i_rst) !(o_high && o_low);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both commands of a leg active");

  property p_dead_gap;
    @(posedge i_mclk) disable iff (i_rst) $fell(o_high) |-> !o_low [*8];
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("low command too soon after high");

  property p_dead_gap_low;
    @(posedge i_mclk) disable iff (i_rst) $fell(o_low) |-> !o_high [*8];
  endproperty
  a_dead_gap_low: assert property (p_dead_gap_low) else $error("high command too soon after low");

  property p_min_on;
    @(posedge i_mclk) disable iff (i_rst || i_block) $rose(o_high) |-> o_high [*8];
  endproperty
  a_min_on: assert property (p_min_on) else $error("high on-pulse too short");

  property p_block_off;
    @(posedge i_mclk) disable iff (i_rst) i_block |=> !o_high && !o_low;
  endproperty
  a_block_off: assert property (p_block_off) else $error("commands active while blocked");
endmodule : phase_leg_ctrl

// *** tb/gate_ctrl_top_tb.sv ***
// self-checking bench for gate_ctrl_top against the power module model
// assumes a pull-up on the enable/fault line, built as the wired level below
`timescale 1ns/10ps
module gate_ctrl_top_tb;
  import gate_ctrl_pkg::*;
  typedef struct packed {logic [1:0] u, v, w; logic [5:0] cmds;} row_t;
  row_t       rows [5] = '{'{2'h1, 2'h2, 2'h0, 6'h0A}, '{2'h2, 2'h1, 2'h1, 6'h31},
                           '{2'h0, 2'h0, 2'h2, 6'h04}, '{2'h3, 2'h1, 2'h0, 6'h10}, '{2'h1, 2'h1, 2'h1, 6'h38}};
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] req [3] = '{2'h0, 2'h0, 2'h0};
  logic       run = 1'b1;
  logic       clr = 1'b0;
  logic       uv_low = 1'b0;
  logic [2:0] uv_high = 3'h0;
  logic       ocp = 1'b0;
  logic       line, drv, oe, flt, pull;
  logic [2:0] hs, ls, ghi, glo;
  int         fails = 0;
  int         samples_checked = 0;
  assign line = (oe ? drv : 1'b1) & !pull;
  gate_ctrl_top dut (.I_MCLK(clk), .I_RST(rst), .I_REQ_U(req[0]), .I_REQ_V(req[1]), .I_REQ_W(req[2]),
    .I_RUN(run), .I_FAULT_CLEAR(clr), .I_ENABLE_FAULT_N_LINE(line), .O_ENABLE_FAULT_N_LINE(drv),
    .O_ENABLE_FAULT_N_LINE_OE(oe), .O_HIGH_SIDE_CMD_U(hs[0]), .O_HIGH_SIDE_CMD_V(hs[1]),
    .O_HIGH_SIDE_CMD_W(hs[2]), .O_LOW_SIDE_CMD_U(ls[0]), .O_LOW_SIDE_CMD_V(ls[1]),
    .O_LOW_SIDE_CMD_W(ls[2]), .O_FAULT_LATCHED(flt));
  power_module_model #(.TMO(200)) model (.i_clk(clk), .i_hin(hs), .i_lin(ls), .i_line(line),
    .i_uv_low(uv_low), .i_uv_high(uv_high), .i_ocp(ocp), .o_gate_hi(ghi), .o_gate_lo(glo), .o_pull(pull));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic give_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    cyc(5);
    rst = 1'b0;
    foreach (rows[k]) begin
      {req[0], req[1], req[2]} = {rows[k].u, rows[k].v, rows[k].w};
      cyc(60);  // past the reset dead time on the first row; the cyc(90) below covers each later row's
      chk("cmds", rows[k].cmds, {hs, ls});
      chk("gates", rows[k].cmds, {ghi, glo});
      {req[0], req[1], req[2]} = 6'h0;
      cyc(90);
    end
    req[0] = 2'h1;
    cyc(60);
    uv_high = 3'h1;
    cyc(10);
    chk("hs_uv", 6'h02, {3'h0, flt, hs[0], ghi[0]});
    uv_high = 3'h0;
    cyc(5);
    chk("hs_latch", 6'h02, {3'h0, flt, hs[0], ghi[0]});
    req[0] = 2'h0;
    cyc(90);
    req[0] = 2'h1;
    cyc(60);
    chk("hs_release", 6'h03, {3'h0, flt, hs[0], ghi[0]});
    req[0] = 2'h0;
    cyc(90);
    for (int f = 0; f < 2; f++) begin
      req[1] = 2'h1;
      cyc(60);
      {uv_low, ocp} = f ? 2'b01 : 2'b10;
      cyc(6);
      chk("trip", 6'h30, {flt, oe, line, |{hs, ls}, |{ghi, glo}, 1'b0});
      cyc(50);
      chk("held", 6'h02, {4'h0, pull, line});
      {uv_low, ocp} = 2'b00;
      req[1] = 2'h0;
      cyc(260);
      chk("kept", 6'h01, {5'h0, oe});
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(5);
      chk("clear", 6'h01, {4'h0, flt, line});
      cyc(40);
    end
    req[0] = 2'h1;
    run = 1'b0;
    cyc(60);
    chk("run_off", 6'h02, {2'h0, |{hs, ls}, flt, oe, line});
    run = 1'b1;
    cyc(5);
    chk("run_on", 6'h01, {4'h0, flt, line});
    cyc(60);
    rst = 1'b1;
    cyc(2);
    chk("rst_cmds", 6'h00, {hs, ls});
    rst = 1'b0;
    cyc(60);
    chk("rst_resume", 6'h08, {hs, ls});
    give_verdict();
  end
endmodule : gate_ctrl_top_tb

// *** tb/power_module_model.sv ***
// behavioural model of the three-phase power module at its control pins
// assumes a pull-up on the shared line; TMO stands in for the long fault timeout
`timescale 1ns/10ps
module power_module_model #(
  parameter int TMO = 200  // fault hold cycles after the cause ends
) (
  input  wire logic       i_clk,      // model time base
  input  wire logic [2:0] i_hin,      // high-side commands W V U
  input  wire logic [2:0] i_lin,      // low-side commands W V U
  input  wire logic       i_line,     // enable/fault line level
  input  wire logic       i_uv_low,   // control supply below lockout
  input  wire logic [2:0] i_uv_high,  // high-side supply low, per phase
  input  wire logic       i_ocp,      // overcurrent trip
  output logic      [2:0] o_gate_hi,  // high switch gates
  output logic      [2:0] o_gate_lo,  // low switch gates
  output logic            o_pull      // pulls the line low
);
  int         timer = 0;
  logic [2:0] latch = 3'h0;
  logic [2:0] h;
  logic [2:0] l;
  logic       en;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      h[i] = (i_hin[i] === 1'b1);  // undriven input reads as off
      l[i] = (i_lin[i] === 1'b1);
    end
    o_pull = i_uv_low || i_ocp || timer != 0;
    en = (i_line === 1'b1) && !i_uv_low && !o_pull;
    o_gate_hi = en ? (h & ~l & ~latch) : 3'h0;
    o_gate_lo = en ? (l & ~h) : 3'h0;
  end
  always @(posedge i_clk) begin
    if (i_uv_low || i_ocp) timer <= TMO;  // timeout only counts once the cause is gone
    else if (timer != 0) timer <= timer - 1;
    for (int i = 0; i < 3; i++)
      if (i_uv_high[i]) latch[i] <= 1'b1;  // one phase only, never reported
      else if (!h[i]) latch[i] <= 1'b0;
  end
endmodule : power_module_model
